// ---- rpm_button.sv ----
// Push-button and external devices on the pulled-up reset line
`default_nettype none
module rpm_button (
  input wire logic press,
  input wire logic pin_o,
  input wire logic pin_oe,
  output logic level
);
  timeunit 1ns;
  timeprecision 1ps;
  // Wired-AND with pull-up: a released line reads high, a held button wins
  assign level = (pin_oe ? pin_o : 1'h1) & !press;
endmodule : rpm_button
`default_nettype wire

// ---- rpm_pkg.sv ----
// Types shared by the reset pin manager modules
`default_nettype none
package rpm_pkg;
  typedef enum logic [1:0] {
    RPM_POWERUP = 2'b00,
    RPM_RUN = 2'b01,
    RPM_USER = 2'b11,
    RPM_SW = 2'b10
  } rpm_state_t;

  typedef enum logic [2:0] {
    RPM_TYPE_GENERAL = 3'h0,
    RPM_TYPE_SOFT = 3'h3,
    RPM_TYPE_USER = 3'h4
  } rpm_type_t;
endpackage : rpm_pkg
`default_nettype wire

// ---- rpm_pulse.sv ----
// Low-pulse shaper for the reset pin
`default_nettype none
module rpm_pulse (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [3:0] exp,
  output logic active_q
);
  logic [16:0] cnt_q;

  // Length minus one of a pulse of 2^(exp+1) cycles
  function automatic logic [16:0] rpm_len_m1(input logic [3:0] e);
    return (17'h00002 << e) - 17'h00001;
  endfunction : rpm_len_m1

  // A start while busy restarts the pulse, so the pin is never released early
  always_ff @(posedge clk) begin
    if (rst) begin
      active_q <= 1'b0;
      cnt_q <= 17'h00000;
    end else if (start) begin
      active_q <= 1'b1;
      cnt_q <= rpm_len_m1(exp);
    end else if (active_q) begin
      if (cnt_q == 17'h00000) begin
        active_q <= 1'b0;
      end else begin
        cnt_q <= cnt_q - 17'h00001;
      end
    end
  end
endmodule : rpm_pulse
`default_nettype wire

// ---- rpm_regs.svh ----
// Register offsets, field positions, reset values and cycle counts of the reset pin manager
// Function
// - Runs on the slow clock and drives an active-low processor reset, peripheral reset and pin drive.
// - The source of the most recent reset is recorded and readable once the processor reset is released.
// - Pin, peripheral and processor resets can be asserted alone or together.
// - The reset state manager raises a request whenever the pin must be driven low and the pin manager acts on it.
// - The mode register lives on the I/O supply and keeps its settings through every core reset.
// - After power-up the pin is driven for the programmed pulse and then released; a pin held low keeps all in reset.
// - The pin is sampled on the slow clock and a low level reports a user reset request.
// - With the user-reset enable bit at 0 a low pin level triggers no user reset.
// - The current pin level is always readable in a status bit.
// - A sticky user-reset-seen bit sets when the pin is asserted and clears only on a status read or a core reset.
// - With the user-reset enable at 0 and the user-reset interrupt enable at 1 a pin assertion gives an interrupt instead of a reset.
// - On request the pin is driven low for a duration set by the pulse-length field.
// - The pulse lasts 2 to the power (field plus one) cycles, two cycles for a field of 0.
// - The pulse-length field resets to 0 on I/O supply reset; the pin then goes low two cycles after core reset release and rises two cycles later.
// - User-reset-seen interrupts only with user reset disabled and its interrupt enabled; a status read clears it.
`ifndef RPM_REGS_SVH
`define RPM_REGS_SVH

`define RPM_OFF_CTRL 12'h000
`define RPM_OFF_STATUS 12'h004
`define RPM_OFF_MODE 12'h008
`define RPM_OFF_IRQ_STAT 12'h00c
`define RPM_OFF_IRQ_MASK 12'h010

`define RPM_CTRL_PROC 0
`define RPM_CTRL_PERIPH 2
`define RPM_CTRL_EXT 3

`define RPM_ST_SEEN 0
`define RPM_ST_TYPE_LO 8
`define RPM_ST_TYPE_HI 10
`define RPM_ST_PIN_LEVEL 16
`define RPM_ST_BUSY 17

`define RPM_MODE_URE 0
`define RPM_MODE_UIE 4
`define RPM_MODE_EXP_LO 8
`define RPM_MODE_EXP_HI 11
`define RPM_MODE_RESET 32'h0000_0001

`define RPM_IRQ_PIN_FALL 0
`define RPM_IRQ_PULSE_DONE 1

`define RPM_SW_CYCLES 3'h3
`define RPM_STARTUP_CYCLES 3'h3

`endif

// ---- rpm_sync.sv ----
// Two-stage synchroniser for the reset pin input
`default_nettype none
module rpm_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic d,
  output logic q
);
  logic meta_q;

  // Idle level of the pin is high, so both stages come out of reset high
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= 1'b1;
      q <= 1'b1;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : rpm_sync
`default_nettype wire

// ---- rpm_top.sv ----
// Reset pin manager and reset state manager with APB register access
//
// The implementer's own choices: the register addresses and the APB register port.
`include "rpm_regs.svh"
`default_nettype none
module rpm_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic io_supply_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pin_i,
  output logic pin_o,
  output logic pin_oe,
  output logic proc_rst_n,
  output logic periph_rst_n,
  output logic irq
);
  logic pin_s;
  logic pin_prev_q;
  logic pin_fall;
  logic pulse_active;
  logic pulse_prev_q;
  logic pulse_done;
  logic pulse_start_q;
  logic ignore_q;

  logic ure_q;
  logic uie_q;
  logic [3:0] exp_q;

  rpm_pkg::rpm_state_t state_q;
  logic [2:0] cnt_q;
  logic [2:0] sw_cmd_q;
  rpm_pkg::rpm_type_t type_q;
  rpm_pkg::rpm_type_t type_pend_q;
  logic proc_hold;
  logic periph_hold;

  logic seen_q;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_mask_q;

  logic setup_acc;
  logic done;
  logic wr_en;
  logic rd_status;
  logic sw_go;
  logic user_go;
  logic mapped;
  logic [31:0] rd_word;

  function automatic logic rpm_hit(input logic [11:0] a, input logic [11:0] off);
    return a[11:2] == off[11:2];
  endfunction : rpm_hit

  // Pin input handling

  rpm_sync u_sync (
    .clk(clk),
    .rst(rst),
    .d(pin_i),
    .q(pin_s)
  );

  rpm_pulse u_pulse (
    .clk(clk),
    .rst(rst),
    .start(pulse_start_q),
    .exp(exp_q),
    .active_q(pulse_active)
  );

  assign pin_fall = pin_prev_q & ~pin_s;
  assign pulse_done = pulse_prev_q & ~pulse_active;

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_prev_q <= 1'b1;
      pulse_prev_q <= 1'b0;
    end else begin
      pin_prev_q <= pin_s;
      pulse_prev_q <= pulse_active;
    end
  end

  // Our own pulse reads back low for a while after release; that low never looks like a user reset if the pulse-length field is above 0 (two-cycle pulses can)
  always_ff @(posedge clk) begin
    if (rst) begin
      ignore_q <= 1'b1;
    end else if (pulse_active) begin
      ignore_q <= 1'b1;
    end else if (pin_s) begin
      ignore_q <= 1'b0;
    end
  end

  // APB slave: pready rises in the second access cycle

  assign setup_acc = psel & penable & ~pready;
  assign done = psel & penable & pready;
  assign wr_en = done & pwrite;
  assign rd_status = done & ~pwrite & rpm_hit(paddr, `RPM_OFF_STATUS);
  assign mapped = rpm_hit(paddr, `RPM_OFF_CTRL) | rpm_hit(paddr, `RPM_OFF_STATUS) |
                  rpm_hit(paddr, `RPM_OFF_MODE) | rpm_hit(paddr, `RPM_OFF_IRQ_STAT) |
                  rpm_hit(paddr, `RPM_OFF_IRQ_MASK);

  always_comb begin
    rd_word = 32'h0000_0000;
    if (rpm_hit(paddr, `RPM_OFF_STATUS)) begin
      rd_word[`RPM_ST_SEEN] = seen_q;
      rd_word[`RPM_ST_TYPE_HI:`RPM_ST_TYPE_LO] = type_q;
      rd_word[`RPM_ST_PIN_LEVEL] = pin_s;
      rd_word[`RPM_ST_BUSY] = (state_q == rpm_pkg::RPM_SW);
    end else if (rpm_hit(paddr, `RPM_OFF_MODE)) begin
      rd_word[`RPM_MODE_URE] = ure_q;
      rd_word[`RPM_MODE_UIE] = uie_q;
      rd_word[`RPM_MODE_EXP_HI:`RPM_MODE_EXP_LO] = exp_q;
    end else if (rpm_hit(paddr, `RPM_OFF_IRQ_STAT)) begin
      rd_word[1:0] = irq_stat_q;
    end else if (rpm_hit(paddr, `RPM_OFF_IRQ_MASK)) begin
      rd_word[1:0] = irq_mask_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= setup_acc;
      if (setup_acc) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_word;
        pslverr <= ~mapped;
      end else begin
        prdata <= 32'h0000_0000;
        pslverr <= 1'b0;
      end
    end
  end

  // Mode register sits on the I/O supply reset, untouched by the core reset
  always_ff @(posedge clk) begin
    if (io_supply_rst) begin
      ure_q <= 1'((`RPM_MODE_RESET >> `RPM_MODE_URE));
      uie_q <= 1'((`RPM_MODE_RESET >> `RPM_MODE_UIE));
      exp_q <= 4'((`RPM_MODE_RESET >> `RPM_MODE_EXP_LO));
    end else if (wr_en && rpm_hit(paddr, `RPM_OFF_MODE)) begin
      ure_q <= pwdata[`RPM_MODE_URE];
      uie_q <= pwdata[`RPM_MODE_UIE];
      exp_q <= pwdata[`RPM_MODE_EXP_HI:`RPM_MODE_EXP_LO];
    end
  end

  // Reset state manager

  // Control writes while a software reset runs are dropped
  assign sw_go = wr_en && rpm_hit(paddr, `RPM_OFF_CTRL) && (state_q == rpm_pkg::RPM_RUN) &&
                 (pwdata[`RPM_CTRL_PROC] | pwdata[`RPM_CTRL_PERIPH] | pwdata[`RPM_CTRL_EXT]);
  assign user_go = ~pin_s & ure_q & ~ignore_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= rpm_pkg::RPM_POWERUP;
      cnt_q <= `RPM_STARTUP_CYCLES;
      sw_cmd_q <= 3'h0;
    end else begin
      case (state_q)
        rpm_pkg::RPM_POWERUP: begin
          // Held until our pulse ends and nobody else keeps the pin low
          if (!pulse_active && !pulse_start_q && pin_s) begin
            state_q <= rpm_pkg::RPM_RUN;
          end
        end
        rpm_pkg::RPM_RUN: begin
          if (sw_go) begin
            state_q <= rpm_pkg::RPM_SW;
            cnt_q <= `RPM_SW_CYCLES - 3'h1;
            sw_cmd_q <= {pwdata[`RPM_CTRL_EXT], pwdata[`RPM_CTRL_PERIPH], pwdata[`RPM_CTRL_PROC]};
          end else if (user_go) begin
            state_q <= rpm_pkg::RPM_USER;
            cnt_q <= `RPM_STARTUP_CYCLES - 3'h1;
          end
        end
        rpm_pkg::RPM_USER: begin
          // Processor startup time counts only once the pin is seen high again
          if (!pin_s) begin
            cnt_q <= `RPM_STARTUP_CYCLES - 3'h1;
          end else if (cnt_q == 3'h0) begin
            state_q <= rpm_pkg::RPM_RUN;
          end else begin
            cnt_q <= cnt_q - 3'h1;
          end
        end
        rpm_pkg::RPM_SW: begin
          if (cnt_q == 3'h0) begin
            state_q <= rpm_pkg::RPM_RUN;
            sw_cmd_q <= 3'h0;
          end else begin
            cnt_q <= cnt_q - 3'h1;
          end
        end
        default: begin
          state_q <= rpm_pkg::RPM_POWERUP;
        end
      endcase
    end
  end

  // Pin drive requests: power-up and the software external-reset command
  always_ff @(posedge clk) begin
    if (rst) begin
      pulse_start_q <= 1'b1;
    end else begin
      pulse_start_q <= sw_go & pwdata[`RPM_CTRL_EXT];
    end
  end

  assign proc_hold = (state_q == rpm_pkg::RPM_POWERUP) | (state_q == rpm_pkg::RPM_USER) |
                     ((state_q == rpm_pkg::RPM_SW) & sw_cmd_q[0]);
  assign periph_hold = (state_q == rpm_pkg::RPM_POWERUP) | (state_q == rpm_pkg::RPM_USER) |
                       ((state_q == rpm_pkg::RPM_SW) & sw_cmd_q[1]);

  always_ff @(posedge clk) begin
    if (rst) begin
      proc_rst_n <= 1'b0;
      periph_rst_n <= 1'b0;
      pin_o <= 1'b0;
      pin_oe <= 1'b0;
    end else begin
      proc_rst_n <= ~proc_hold;
      periph_rst_n <= ~periph_hold;
      pin_o <= 1'b0;
      pin_oe <= pulse_active;
    end
  end

  // Reset source: latched on entry, shown only when the processor reset is released
  always_ff @(posedge clk) begin
    if (rst) begin
      type_pend_q <= rpm_pkg::RPM_TYPE_GENERAL;
      type_q <= rpm_pkg::RPM_TYPE_GENERAL;
    end else begin
      if (state_q == rpm_pkg::RPM_RUN && sw_go && pwdata[`RPM_CTRL_PROC]) begin
        type_pend_q <= rpm_pkg::RPM_TYPE_SOFT;
      end else if (state_q == rpm_pkg::RPM_RUN && !sw_go && user_go) begin
        type_pend_q <= rpm_pkg::RPM_TYPE_USER;
      end
      if (!proc_rst_n && !proc_hold) begin
        type_q <= type_pend_q;
      end
    end
  end

  // Status and interrupts: a hardware set in the clearing cycle wins
  always_ff @(posedge clk) begin
    if (rst) begin
      seen_q <= 1'b0;
    end else if (pin_fall) begin
      seen_q <= 1'b1;
    end else if (rd_status) begin
      seen_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_stat_q <= 2'h0;
    end else begin
      if (pin_fall) begin
        irq_stat_q[`RPM_IRQ_PIN_FALL] <= 1'b1;
      end else if (wr_en && rpm_hit(paddr, `RPM_OFF_IRQ_STAT) && pwdata[`RPM_IRQ_PIN_FALL]) begin
        irq_stat_q[`RPM_IRQ_PIN_FALL] <= 1'b0;
      end
      if (pulse_done) begin
        irq_stat_q[`RPM_IRQ_PULSE_DONE] <= 1'b1;
      end else if (wr_en && rpm_hit(paddr, `RPM_OFF_IRQ_STAT) && pwdata[`RPM_IRQ_PULSE_DONE]) begin
        irq_stat_q[`RPM_IRQ_PULSE_DONE] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_mask_q <= 2'h0;
    end else if (wr_en && rpm_hit(paddr, `RPM_OFF_IRQ_MASK)) begin
      irq_mask_q <= pwdata[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= (seen_q & ~ure_q & uie_q) | (|(irq_stat_q & irq_mask_q));
    end
  end
endmodule : rpm_top
`default_nettype wire

// ---- rpm_top_sva.sv ----
// Port checker of the reset pin manager
`default_nettype none
module rpm_top_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic io_supply_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pin_i,
  input wire logic pin_o,
  input wire logic pin_oe,
  input wire logic proc_rst_n,
  input wire logic periph_rst_n,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] exp_q;
  logic ure_q;
  logic [15:0] cnt_q;
  // Shadow of the mode register; it survives core reset just like the real one
  always_ff @(posedge clk) begin
    if (io_supply_rst) begin
      exp_q <= 4'h0;
      ure_q <= 1'h1;
    end else if (psel && penable && pready && pwrite && paddr == 12'h008) begin
      exp_q <= pwdata[11:8];
      ure_q <= pwdata[0];
    end
  end
  always_ff @(posedge clk) begin
    cnt_q <= (rst || !pin_oe) ? 16'h0 : cnt_q + 16'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_reset_out;
    $fell(rst) |-> (!proc_rst_n && !periph_rst_n && !pin_oe && !irq) ##2 pin_oe;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("bad outputs after reset");
  property p_pin_drive;
    pin_oe |-> !pin_o;
  endproperty
  a_pin_drive: assert property (p_pin_drive) else $error("pin driven high");
  property p_pulse_len;
    $fell(pin_oe) |-> cnt_q == (16'h2 << exp_q);
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("pulse length wrong");
  property p_apb_answer;
    psel && !penable |-> ##2 pready && pslverr == (paddr > 12'h010);
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("bus answer wrong");
  property p_pready_once;
    pready |-> penable ##1 !pready;
  endproperty
  a_pready_once: assert property (p_pready_once) else $error("ready too long");
  property p_user_rst;
    (ure_q && !pin_oe && !pin_i) [*7] |-> !proc_rst_n && !periph_rst_n;
  endproperty
  a_user_rst: assert property (p_user_rst) else $error("low pin gave no reset");
  property p_no_user_rst;
    $fell(pin_i) && !ure_q && !pin_oe && proc_rst_n |=> proc_rst_n [*8];
  endproperty
  a_no_user_rst: assert property (p_no_user_rst) else $error("disabled pin reset");
  property p_pin_level;
    $stable(pin_i) [*6] ##0 (pready && !pwrite && paddr == 12'h004) |-> prdata[16] == pin_i;
  endproperty
  a_pin_level: assert property (p_pin_level) else $error("pin level wrong");
endmodule : rpm_top_sva
bind rpm_top rpm_top_sva u_sva (.clk, .rst, .io_supply_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .pin_i, .pin_o, .pin_oe, .proc_rst_n, .periph_rst_n, .irq);
`default_nettype wire

// ---- tb.sv ----
// Self-checking bench of the reset pin manager
`default_nettype none
`define chk(nm, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0, rst = 1'h1, io_rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, press = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, pin, pin_o, pin_oe, proc_rst_n, periph_rst_n, irq, err;
  int errors = 0, comparisons = 0, cyc = 0;
  rpm_top dut (.clk, .rst, .io_supply_rst(io_rst), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .pin_i(pin), .pin_o, .pin_oe, .proc_rst_n, .periph_rst_n, .irq);
  rpm_button ext (.press, .pin_o, .pin_oe, .level(pin));
  initial begin
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      conclude();
    end
  end
  task automatic conclude();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic pulse(output int len);
    do @(posedge clk); while (pin_oe !== 1'h1);
    len = 0;
    while (pin_oe === 1'h1) begin
      len++;
      @(posedge clk);
    end
  endtask : pulse
  task automatic t_powerup();
    int len;
    pulse(len);
    `chk("startup pulse", 2, len)
    while (proc_rst_n !== 1'h1) @(posedge clk);
    `chk("periph out", 1'h1, periph_rst_n)
    apb(1'h0, 12'h004, 32'h0);
    `chk("general type", 3'h0, rd[10:8])
    apb(1'h0, 12'h020, 32'h0);
    `chk("unmapped err", 1'h1, err)
  endtask : t_powerup
  task automatic t_ext();
    int len;
    apb(1'h1, 12'h008, 32'h0000_0201);
    apb(1'h1, 12'h000, 32'h0000_0008);
    pulse(len);
    `chk("ext pulse", 8, len)
    `chk("proc kept", 1'h1, proc_rst_n)
    apb(1'h0, 12'h00c, 32'h0);
    `chk("pulse done", 1'h1, rd[1])
  endtask : t_ext
  task automatic t_core();
    int len;
    rst <= 1'h1;
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    pulse(len);
    `chk("kept pulse", 8, len)
    io_rst <= 1'h1;
    @(posedge clk);
    io_rst <= 1'h0;
    apb(1'h0, 12'h008, 32'h0);
    `chk("io reset mode", 32'h0000_0001, rd)
    while (proc_rst_n !== 1'h1) @(posedge clk);
  endtask : t_core
  task automatic t_soft();
    apb(1'h1, 12'h000, 32'h0000_0004);
    while (periph_rst_n !== 1'h0) @(posedge clk);
    `chk("periph alone", 1'h1, proc_rst_n)
    while (periph_rst_n !== 1'h1) @(posedge clk);
    apb(1'h1, 12'h000, 32'h0000_0005);
    while (proc_rst_n !== 1'h0) @(posedge clk);
    `chk("periph with proc", 1'h0, periph_rst_n)
    while (proc_rst_n !== 1'h1) @(posedge clk);
    apb(1'h0, 12'h004, 32'h0);
    `chk("soft type", 3'h3, rd[10:8])
  endtask : t_soft
  task automatic t_user();
    press <= 1'h1;
    while (proc_rst_n !== 1'h0) @(posedge clk);
    repeat (10) @(posedge clk);
    `chk("held periph", 1'h0, periph_rst_n)
    apb(1'h0, 12'h004, 32'h0);
    `chk("seen set", 1'h1, rd[0])
    `chk("level low", 1'h0, rd[16])
    apb(1'h0, 12'h004, 32'h0);
    `chk("seen cleared", 1'h0, rd[0])
    press <= 1'h0;
    while (proc_rst_n !== 1'h1) @(posedge clk);
    apb(1'h0, 12'h004, 32'h0);
    `chk("user type", 3'h4, rd[10:8])
  endtask : t_user
  task automatic t_irq();
    apb(1'h1, 12'h00c, 32'h0000_0003);
    apb(1'h1, 12'h008, 32'h0000_0010);
    press <= 1'h1;
    repeat (10) @(posedge clk);
    `chk("no user reset", 1'h1, proc_rst_n)
    `chk("seen irq", 1'h1, irq)
    press <= 1'h0;
    apb(1'h0, 12'h004, 32'h0);
    repeat (3) @(posedge clk);
    `chk("irq read clear", 1'h0, irq)
    apb(1'h1, 12'h010, 32'h0000_0001);
    repeat (3) @(posedge clk);
    `chk("masked fall irq", 1'h1, irq)
    apb(1'h1, 12'h00c, 32'h0000_0001);
    repeat (3) @(posedge clk);
    `chk("w1c irq", 1'h0, irq)
  endtask : t_irq
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    io_rst <= 1'h0;
    t_powerup();
    t_ext();
    t_core();
    t_soft();
    t_user();
    t_irq();
    conclude();
  end
endmodule : tb
`default_nettype wire
